// ===== rtl/ep_cfg_defs.svh
/*
 * Constants of the endpoint configuration block: register offsets, field
 * positions, code values and geometry.
 * Assumes it is included by its bare name from the design files.
 */
`ifndef EP_CFG_DEFS_SVH
`define EP_CFG_DEFS_SVH

// Byte offsets on the register bus.
`define OFF_PACKET_SIZE   8'h04
`define OFF_TYPE_CONFIG   8'h08
`define OFF_BYTE_COUNT    8'h1c
`define OFF_EP_INDEX      8'h20

// Endpoint geometry.
`define EP_COUNT          16
`define EP_IDX_W          4
`define EP_CTRL_OUT       4'h0
`define EP_CTRL_IN        4'h1
`define EP_SETUP          4'h2

// Packet size register fields.
`define PSIZE_W           13
`define FIFO_SIZE_MSB     10
`define TRANSACTIONS_PER_MICROFRAME_LSB        11
`define TRANSACTIONS_PER_MICROFRAME_MSB        12

// Endpoint type register fields.
`define TYPE_W            5
`define TYPE_MSB          1
`define DOUBLE_BUFFER_ENABLE_BIT        2
`define ENABLE_BIT        3
`define NOZLP_BIT         4

// Transfer type codes.
`define XFER_UNUSED       2'h0
`define XFER_ISO          2'h1
`define XFER_BULK         2'h2
`define XFER_INT          2'h3

// Transactions per microframe codes.
`define TRANSACTIONS_PER_MICROFRAME_ONE        2'h0
`define TRANSACTIONS_PER_MICROFRAME_TWO        2'h1
`define TRANSACTIONS_PER_MICROFRAME_THREE      2'h2
`define TRANSACTIONS_PER_MICROFRAME_RSVD       2'h3

// Buffer counts.
`define BUF_NONE          2'h0
`define BUF_SINGLE        2'h1
`define BUF_DOUBLE        2'h2
`endif

// ===== rtl/ep_cfg_pkg.sv
/*
 * Types shared by the endpoint configuration block and its memory.
 * Assumes ep_cfg_defs.svh is on the include path.
 */
`include "ep_cfg_defs.svh"

package ep_cfg_pkg;
    // One stored word per endpoint.
    typedef struct packed {
        logic [15:0]           byte_count;
        logic [`TYPE_W-1:0]    type_bits;
        logic [`PSIZE_W-1:0]   psize_bits;
    } ep_word_t;

    typedef logic [`EP_IDX_W-1:0] ep_idx_t;

    // Bus handshake states.
    typedef enum logic [2:0] {
        BUS_IDLE = 3'b001,
        BUS_WAIT = 3'b010,
        BUS_DONE = 3'b100
    } bus_state_t;
endpackage : ep_cfg_pkg

// ===== rtl/ep_cfg_mem_if.sv
/*
 * Connection between the register block and its endpoint memory.
 * Assumes one clock shared by both ends.
 */
interface ep_cfg_mem_if;
    import ep_cfg_pkg::*;
    logic     clear;
    logic     we_psize;
    logic     we_type;
    logic     we_count;
    ep_idx_t  waddr;
    ep_word_t wdata;
    ep_idx_t  raddr_a;
    ep_word_t rdata_a;
    ep_idx_t  raddr_b;
    ep_word_t rdata_b;

    modport master (output clear, we_psize, we_type, we_count, waddr, wdata,
                    output raddr_a, raddr_b, input rdata_a, rdata_b);
    modport mem    (input clear, we_psize, we_type, we_count, waddr, wdata,
                    input raddr_a, raddr_b, output rdata_a, rdata_b);
endinterface : ep_cfg_mem_if

// ===== rtl/ep_cfg_mem.sv
/*
 * Per-endpoint word store with one masked write port and two registered
 * read ports.
 * Assumes pclk and presetn of the register block; clear is synchronous.
 */
module ep_cfg_mem
    import ep_cfg_pkg::*;
(
    // Clock and reset.
    input  wire logic   pclk,
    input  wire logic   presetn,
    // Access port.
    ep_cfg_mem_if.mem   m
);
    ep_word_t words [`EP_COUNT];

    // Fields are written under their own enables so that one write does not
    // disturb the other fields of the same endpoint.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < `EP_COUNT; i++)
                words[i] <= '0;
        end
        else if (m.clear)
        begin
            for (int i = 0; i < `EP_COUNT; i++)
                words[i] <= '0;
        end
        else
        begin
            if (m.we_psize)
                words[m.waddr].psize_bits <= m.wdata.psize_bits;
            if (m.we_type)
                words[m.waddr].type_bits <= m.wdata.type_bits;
            if (m.we_count)
                words[m.waddr].byte_count <= m.wdata.byte_count;
        end
    end

    // Read data leave through registers.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            m.rdata_a <= '0;
            m.rdata_b <= '0;
        end
        else
        begin
            m.rdata_a <= words[m.raddr_a];
            m.rdata_b <= words[m.raddr_b];
        end
    end
endmodule : ep_cfg_mem

// ===== rtl/usb_endpoint_config_regs.sv
/*
 * Endpoint configuration registers of a high-speed USB peripheral: an
 * index register, the packet size and endpoint type registers and the
 * packet byte count, reached over APB, plus the decoded configuration of
 * the endpoint that the transfer engine currently serves.
 * Assumes a single 20 MHz clock, inputs synchronous to it, and an engine
 * that holds eng_ep steady while it uses the outputs.
 */
// Our own choice: register access over APB.
// What this block does
// - Packet size write reloads byte count
// - Codes 0..2 give one to three packets
// - Multi-packet only high-speed iso or interrupt
// - Eleven-bit field gives FIFO size bytes
// - Control and setup sizes not governed here
// - Two-bit code selects endpoint transfer type
// - Null packet after DMA IN unless suppressed
// - Enable bit activates and allocates endpoint FIFO
// - Disable then enable resets data toggle
// - Double-buffer bit selects two alternating buffers
// - Byte count holds current packet size
`include "ep_cfg_defs.svh"

module usb_endpoint_config_regs
(
    // Clock and reset.
    input  wire  logic                  pclk,
    input  wire  logic                  presetn,
    // APB slave.
    input  wire  logic [7:0]            paddr,
    input  wire  logic                  psel,
    input  wire  logic                  penable,
    input  wire  logic                  pwrite,
    input  wire  logic [31:0]           pwdata,
    output logic       [31:0]           prdata,
    output logic                        pready,
    output logic                        pslverr,
    // Link state.
    input  wire  logic                  hs_mode,
    input  wire  logic                  usb_bus_reset,
    // Transfer engine side.
    input  wire  ep_cfg_pkg::ep_idx_t   eng_ep,
    input  wire  logic                  dma_in_done,
    input  wire  logic                  zlp_sent,
    input  wire  logic                  rx_count_valid,
    input  wire  logic [15:0]           rx_count,
    // Decoded configuration of the served endpoint; toggle reset of the indexed one.
    output logic                        ep_enabled,
    output logic       [1:0]            endpoint_transfer_type,
    output logic       [10:0]           fifo_alloc_bytes,
    output logic       [1:0]            ep_buffers,
    output logic       [1:0]            packets_per_uframe,
    output logic                        suppress_null_packet,
    output logic                        send_null_packet,
    output logic       [15:0]           packet_byte_count,
    output logic                        toggle_reset,
    output ep_cfg_pkg::ep_idx_t         toggle_reset_ep
);
    import ep_cfg_pkg::*;

    // True when the endpoint's size is fixed outside this register.
    function automatic logic fixed_size(input ep_idx_t ep);
        fixed_size = (ep == `EP_CTRL_OUT) || (ep == `EP_CTRL_IN) ||
                     (ep == `EP_SETUP);
    endfunction : fixed_size

    // Packets allowed per microframe, encoded as count minus one.
    function automatic logic [1:0] ppmf(input logic hs,
                                        input logic [`TYPE_W-1:0] t,
                                        input logic [1:0] nt);
        logic periodic;
        periodic = (t[`TYPE_MSB:0] == `XFER_ISO) ||
                   (t[`TYPE_MSB:0] == `XFER_INT);
        if (hs && periodic && t[`ENABLE_BIT] && nt != `TRANSACTIONS_PER_MICROFRAME_RSVD)
            ppmf = nt;
        else
            ppmf = `TRANSACTIONS_PER_MICROFRAME_ONE;
    endfunction : ppmf

    ep_cfg_mem_if mif ();

    bus_state_t          bus_state_reg;
    bus_state_t          bus_state_next;
    ep_idx_t             index_reg;
    logic [31:0]         prdata_reg;
    logic                pslverr_reg;
    logic                pready_reg;
    logic                pend_reg;
    ep_idx_t             pend_ep_reg;
    logic [15:0]         pend_cnt_reg;
    logic [`EP_COUNT-1:0] zlp_pend_reg;
    logic                ep_enabled_reg;
    logic [1:0]          xfer_type_reg;
    logic [10:0]         alloc_reg;
    logic [1:0]          buffers_reg;
    logic [1:0]          ppmf_reg;
    logic                nozlp_reg;
    logic                send_zlp_reg;
    logic [15:0]         count_out_reg;
    logic                toggle_reg;
    ep_idx_t             toggle_ep_reg;

    // Bus decode.
    wire logic hit_psize  = (paddr == `OFF_PACKET_SIZE);
    wire logic hit_type   = (paddr == `OFF_TYPE_CONFIG);
    wire logic hit_count  = (paddr == `OFF_BYTE_COUNT);
    wire logic hit_index  = (paddr == `OFF_EP_INDEX);
    wire logic hit_any    = hit_psize | hit_type | hit_count | hit_index;
    wire logic access     = psel & penable;
    wire logic commit     = access & pready_reg;
    wire logic answer     = access & (bus_state_reg == BUS_IDLE);
    wire logic wr_commit  = commit & pwrite & ~usb_bus_reset;
    wire logic wr_psize   = wr_commit & hit_psize & ~fixed_size(index_reg);
    wire logic wr_type    = wr_commit & hit_type;
    wire logic wr_count   = wr_commit & hit_count;
    wire logic bus_mem_wr = wr_psize | wr_type | wr_count;
    wire logic pend_go    = pend_reg & ~bus_mem_wr;

    // Data seen at the indexed endpoint and at the served endpoint.
    wire ep_word_t       idx_word   = mif.rdata_a;
    wire ep_word_t       eng_word   = mif.rdata_b;
    wire logic [31:0]    rd_psize   = fixed_size(index_reg) ? 32'h0 :
                                      {19'h0, idx_word.psize_bits};
    wire logic [31:0]    rd_type    = {27'h0, idx_word.type_bits};
    wire logic [31:0]    rd_count   = {16'h0, idx_word.byte_count};
    wire logic [31:0]    rd_index   = {28'h0, index_reg};
    wire logic [31:0]    rd_mux     = hit_psize ? rd_psize :
                                      hit_type  ? rd_type  :
                                      hit_count ? rd_count :
                                      hit_index ? rd_index : 32'h0;

    // Write data for the memory, one field per source.
    wire logic [`PSIZE_W-1:0] new_psize = pwdata[`PSIZE_W-1:0];
    wire logic [15:0] reload_count =
        {5'h0, pwdata[`FIFO_SIZE_MSB:0]};
    wire logic [15:0] bus_count = hit_count ? pwdata[15:0] : reload_count;
    wire logic [`TYPE_W-1:0] new_type = pwdata[`TYPE_W-1:0];

    // Rising enable edge on a type write; the old value is the indexed
    // word, which is current because the bus waits one cycle.
    wire logic enable_rise = wr_type & ~idx_word.type_bits[`ENABLE_BIT] &
                             pwdata[`ENABLE_BIT];

    // Memory connection; the bus port always follows the index.
    assign mif.clear    = usb_bus_reset;
    assign mif.we_psize = wr_psize;
    assign mif.we_type  = wr_type;
    assign mif.we_count = wr_psize | wr_count | pend_go;
    assign mif.waddr    = bus_mem_wr ? index_reg : pend_ep_reg;
    assign mif.wdata    = bus_mem_wr ?
                          '{byte_count: bus_count, type_bits: new_type,
                            psize_bits: new_psize} :
                          '{byte_count: pend_cnt_reg, type_bits: '0,
                            psize_bits: '0};
    assign mif.raddr_a  = index_reg;
    assign mif.raddr_b  = eng_ep;

    ep_cfg_mem u_mem
    (
        .pclk    (pclk),
        .presetn (presetn),
        .m       (mif.mem)
    );

    // Bus handshake: one wait cycle lets the memory read settle, so every
    // transfer takes setup plus two access cycles.
    always_comb
    begin
        bus_state_next = bus_state_reg;
        unique case (bus_state_reg)
            BUS_IDLE: if (access) bus_state_next = BUS_WAIT;
            BUS_WAIT: bus_state_next = BUS_DONE;
            BUS_DONE: bus_state_next = BUS_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            bus_state_reg <= BUS_IDLE;
        else
            bus_state_reg <= bus_state_next;
    end

    // Answer registers: ready, read data and error are loaded together.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_reg  <= 1'b0;
            prdata_reg  <= 32'h0;
            pslverr_reg <= 1'b0;
        end
        else
        begin
            pready_reg  <= answer;
            prdata_reg  <= (answer & ~pwrite) ? rd_mux : 32'h0;
            pslverr_reg <= answer & ~hit_any;
        end
    end

    // The index survives a bus reset; the configuration, the pending byte count and the pending null packets are cleared.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            index_reg <= '0;
        else if (commit & pwrite & hit_index)
            index_reg <= pwdata[`EP_IDX_W-1:0];
    end

    // Received byte counts wait here while the bus owns the write port.
    // A new count replaces an older one still waiting; the engine reports
    // at most one per packet, far slower than the bus can stall it.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pend_reg     <= 1'b0;
            pend_ep_reg  <= '0;
            pend_cnt_reg <= 16'h0;
        end
        else if (usb_bus_reset)
            pend_reg <= 1'b0;
        else if (rx_count_valid)
        begin
            pend_reg     <= 1'b1;
            pend_ep_reg  <= eng_ep;
            pend_cnt_reg <= rx_count;
        end
        else if (pend_go)
            pend_reg <= 1'b0;
    end

    // One pending null packet per endpoint; a new DMA completion in the
    // cycle the packet goes out keeps the request alive.
    wire logic zlp_set = dma_in_done & ~eng_word.type_bits[`NOZLP_BIT] &
                         eng_word.type_bits[`ENABLE_BIT];
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            zlp_pend_reg <= '0;
        else if (usb_bus_reset)
            zlp_pend_reg <= '0;
        else if (zlp_set)
            zlp_pend_reg[eng_ep] <= 1'b1;
        else if (zlp_sent)
            zlp_pend_reg[eng_ep] <= 1'b0;
    end

    // Decoded view of the served endpoint.
    wire logic        eng_en   = eng_word.type_bits[`ENABLE_BIT];
    wire logic [1:0]  eng_ty   = eng_word.type_bits[`TYPE_MSB:0];
    wire logic [10:0] eng_size = eng_word.psize_bits[`FIFO_SIZE_MSB:0];
    wire logic [1:0]  eng_nt   = eng_word.psize_bits[`TRANSACTIONS_PER_MICROFRAME_MSB:`TRANSACTIONS_PER_MICROFRAME_LSB];
    wire logic [1:0]  eng_bufs = ~eng_en ? `BUF_NONE :
                                 eng_word.type_bits[`DOUBLE_BUFFER_ENABLE_BIT] ?
                                 `BUF_DOUBLE : `BUF_SINGLE;
    wire logic [10:0] eng_alloc = eng_en ? eng_size : 11'h0;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ep_enabled_reg <= 1'b0;
            xfer_type_reg  <= `XFER_UNUSED;
            alloc_reg      <= 11'h0;
            buffers_reg    <= `BUF_NONE;
            ppmf_reg       <= `TRANSACTIONS_PER_MICROFRAME_ONE;
            nozlp_reg      <= 1'b0;
            send_zlp_reg   <= 1'b0;
            count_out_reg  <= 16'h0;
        end
        else
        begin
            ep_enabled_reg <= eng_en;
            xfer_type_reg  <= eng_ty;
            alloc_reg      <= eng_alloc;
            buffers_reg    <= eng_bufs;
            ppmf_reg       <= ppmf(hs_mode, eng_word.type_bits,
                                   eng_nt);
            nozlp_reg      <= eng_word.type_bits[`NOZLP_BIT];
            send_zlp_reg   <= zlp_pend_reg[eng_ep] & ~zlp_sent;
            count_out_reg  <= eng_word.byte_count;
        end
    end

    // Re-enabling an endpoint resets its data toggle; a stall alone does
    // not, so firmware must disable and enable to recover.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            toggle_reg    <= 1'b0;
            toggle_ep_reg <= '0;
        end
        else
        begin
            toggle_reg    <= enable_rise;
            toggle_ep_reg <= index_reg;
        end
    end

    // Outputs straight from registers.
    assign prdata                 = prdata_reg;
    assign pready                 = pready_reg;
    assign pslverr                = pslverr_reg;
    assign ep_enabled             = ep_enabled_reg;
    assign endpoint_transfer_type = xfer_type_reg;
    assign fifo_alloc_bytes       = alloc_reg;
    assign ep_buffers             = buffers_reg;
    assign packets_per_uframe     = ppmf_reg;
    assign suppress_null_packet   = nozlp_reg;
    assign send_null_packet       = send_zlp_reg;
    assign packet_byte_count      = count_out_reg;
    assign toggle_reset           = toggle_reg;
    assign toggle_reset_ep        = toggle_ep_reg;
endmodule : usb_endpoint_config_regs

// ===== tb/ep_cfg_monitor.sv
/*
 * Port checker of the endpoint block, bound to its top.
 * Assumes the single clock pclk and the active-low reset presetn.
 */
`include "ep_cfg_defs.svh"

module ep_cfg_monitor
(
    // Clock and reset.
    input  wire logic                pclk,
    input  wire logic                presetn,
    // APB slave.
    input  wire logic [7:0]          paddr,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [31:0]         prdata,
    input  wire logic                pready,
    input  wire logic                pslverr,
    // Engine side.
    input  wire logic                dma_in_done,
    input  wire logic                ep_enabled,
    input  wire logic [1:0]          endpoint_transfer_type,
    input  wire logic [10:0]         fifo_alloc_bytes,
    input  wire logic [1:0]          ep_buffers,
    input  wire logic [1:0]          packets_per_uframe,
    input  wire logic                send_null_packet,
    input  wire logic                toggle_reset
);
    timeunit 1ns / 1ns;
    import ep_cfg_pkg::*;

    // All checks run on pclk and sleep in reset.
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Decoded map; anything else must be refused.
    wire mapped = paddr == `OFF_PACKET_SIZE || paddr == `OFF_TYPE_CONFIG ||
                  paddr == `OFF_BYTE_COUNT || paddr == `OFF_EP_INDEX;
    wire rd_done = pready && psel && penable && !pwrite;

    sequence s_first;
        psel && $rose(penable);
    endsequence
    sequence s_answer;
        !pready ##1 (pready && psel && penable);
    endsequence

    property p_wait;
        s_first |-> s_answer;
    endproperty
    property p_pulse;
        pready |=> !pready;
    endproperty
    property p_err;
        pslverr |-> pready && !mapped;
    endproperty
    property p_refuse;
        pready && !mapped |-> pslverr && prdata == 32'h0;
    endproperty
    property p_idle;
        !pready |-> prdata == 32'h0 && !pslverr;
    endproperty
    property p_type_rsv;
        rd_done && paddr == `OFF_TYPE_CONFIG |-> prdata[31:5] == 27'h0;
    endproperty
    property p_size_rsv;
        rd_done && paddr == `OFF_PACKET_SIZE |-> prdata[31:13] == 19'h0;
    endproperty
    property p_alloc;
        !ep_enabled |-> fifo_alloc_bytes == 11'h0 && ep_buffers == `BUF_NONE;
    endproperty
    property p_multi;
        packets_per_uframe != 2'h0 |-> ep_enabled &&
            packets_per_uframe != 2'h3 &&
            (endpoint_transfer_type == `XFER_ISO ||
             endpoint_transfer_type == `XFER_INT);
    endproperty
    property p_null;
        $rose(send_null_packet) |-> $past(dma_in_done, 2);
    endproperty
    property p_tog;
        toggle_reset |=> !toggle_reset;
    endproperty

    a_wait:     assert property (p_wait) else $error("late bus answer");
    a_pulse:    assert property (p_pulse) else $error("long ready");
    a_err:      assert property (p_err) else $error("bad error flag");
    a_refuse:   assert property (p_refuse) else $error("unmapped taken");
    a_idle:     assert property (p_idle) else $error("idle data set");
    a_type_rsv: assert property (p_type_rsv) else $error("type reserved");
    a_size_rsv: assert property (p_size_rsv) else $error("size reserved");
    a_alloc:    assert property (p_alloc) else $error("alloc when off");
    a_multi:    assert property (p_multi) else $error("bad packets");
    a_null:     assert property (p_null) else $error("stray null");
    a_tog:      assert property (p_tog) else $error("long toggle");
endmodule : ep_cfg_monitor

bind usb_endpoint_config_regs ep_cfg_monitor i_ep_cfg_monitor (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .dma_in_done(dma_in_done), .ep_enabled(ep_enabled),
    .endpoint_transfer_type(endpoint_transfer_type),
    .fifo_alloc_bytes(fifo_alloc_bytes), .ep_buffers(ep_buffers),
    .packets_per_uframe(packets_per_uframe),
    .send_null_packet(send_null_packet), .toggle_reset(toggle_reset));

// ===== tb/ep_engine_model.sv
/*
 * Behavioural transfer engine on the block's engine side.
 * Assumes callers enter its tasks right after a rising pclk edge.
 */
module ep_engine_model
(
    // Clock.
    input  wire logic                pclk,
    // Engine strobes.
    output ep_cfg_pkg::ep_idx_t      eng_ep,
    output logic                     dma_in_done,
    output logic                     zlp_sent,
    output logic                     rx_count_valid,
    output logic [15:0]              rx_count
);
    timeunit 1ns;
    timeprecision 1ns;
    import ep_cfg_pkg::*;

    // Quiet engine; the count bus shows junk when idle.
    initial
    begin
        eng_ep = 4'h0;
        dma_in_done = 1'b0;
        zlp_sent = 1'b0;
        rx_count_valid = 1'b0;
        rx_count = 16'hffff;
    end

    // The served endpoint stays put until the next call.
    task serve(input ep_idx_t ep);
        eng_ep <= ep;
    endtask : serve

    // One-cycle strobe: 0 for a finished DMA IN, 1 for a sent null packet.
    task strobe(input logic zlp);
        @(posedge pclk);
        if (zlp) zlp_sent <= 1'b1;
        else dma_in_done <= 1'b1;
        @(posedge pclk);
        zlp_sent <= 1'b0;
        dma_in_done <= 1'b0;
    endtask : strobe

    // Report an OUT packet length, then scramble the bus.
    task rx(input logic [15:0] n);
        @(posedge pclk);
        rx_count_valid <= 1'b1;
        rx_count <= n;
        @(posedge pclk);
        rx_count_valid <= 1'b0;
        rx_count <= ~n;
    endtask : rx
endmodule : ep_engine_model

// ===== tb/usb_endpoint_config_regs_test.sv
/*
 * Self-checking bench of the endpoint configuration block with a
 * register model in integers. Assumes the engine model beside it.
 */
module usb_endpoint_config_regs_test;
    timeunit 1ns;
    timeprecision 1ns;
    import ep_cfg_pkg::*;

    logic        pclk, presetn, psel, penable, pwrite, hs_mode;
    logic        usb_bus_reset, pready, pslverr, dma_in_done, zlp_sent;
    logic        rx_count_valid, ep_enabled, suppress_null_packet;
    logic        send_null_packet, toggle_reset, tr_seen, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rdv;
    logic [15:0] rx_count, packet_byte_count;
    logic [10:0] fifo_alloc_bytes;
    logic [1:0]  endpoint_transfer_type, ep_buffers, packets_per_uframe;
    ep_idx_t     eng_ep, toggle_reset_ep, tr_ep;
    int          errors, total_checks, seed, v, en, nt, ty, hs;
    int          m_ps[16], m_ty[16], m_bc[16];

    usb_endpoint_config_regs i_usb_endpoint_config_regs (.*);
    ep_engine_model i_ep_engine_model (.pclk(pclk), .eng_ep(eng_ep),
        .dma_in_done(dma_in_done), .zlp_sent(zlp_sent),
        .rx_count_valid(rx_count_valid), .rx_count(rx_count));

    // Free-running 20 MHz bus clock.
    initial
    begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    // Latch the one-cycle toggle reset pulse.
    always @(posedge pclk)
    begin
        if (toggle_reset === 1'b1)
        begin
            tr_seen <= 1'b1;
            tr_ep <= toggle_reset_ep;
        end
    end

    task give_verdict;
        if (errors == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : give_verdict

    task chk(input string name, input logic [31:0] seen,
             input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    // One APB transfer; the wait for pready is bounded.
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (n >= 20)
        begin
            errors++;
            give_verdict();
        end
        rdv = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Read back every indexed register.
    task chk_all;
        for (int e = 0; e < 16; e++)
        begin
            apb(1, 8'h20, e);
            apb(0, 8'h04, 0);
            chk("packet_size", rdv, m_ps[e]);
            apb(0, 8'h08, 0);
            chk("type_config", rdv, m_ty[e]);
            apb(0, 8'h1c, 0);
            chk("byte_count", rdv, m_bc[e]);
        end
    endtask : chk_all

    // Configure endpoint e and update the model.
    task cfg(input int e, input int ps, input int t);
        apb(1, 8'h20, e);
        apb(1, 8'h04, ps);
        if (e > 2)
        begin
            m_ps[e] = ps & 32'h1fff;
            m_bc[e] = ps & 32'h7ff;
        end
        apb(1, 8'h08, t);
        m_ty[e] = t & 32'h1f;
    endtask : cfg

    initial
    begin
        {psel, penable, pwrite, hs_mode, usb_bus_reset, tr_seen} = 6'h0;
        paddr = 8'h0;
        pwdata = 32'h0;
        presetn = 1'b0;
        seed = 32'hd28a;
        m_ps = '{default: 0};
        m_ty = '{default: 0};
        m_bc = '{default: 0};
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        chk_all();
        for (int e = 0; e < 16; e++)
            cfg(e, $random(seed) & ~32'h600, $random(seed));
        chk_all();
        apb(0, 8'h10, 0);
        chk("slverr", err, 1);
        chk("unmapped", rdv, 0);
        // Every type and transactions code, both speeds.
        for (int k = 0; k < 32; k++)
        begin
            cfg(5, (k & 12) << 9 | 64 + k, 8 | k & 3 | (k & 16) >> 2);
            hs_mode <= k[4];
            i_ep_engine_model.serve(5);
            repeat (4) @(posedge pclk);
            hs = k[4];
            en = m_ty[5] >> 3 & 1;
            nt = m_ps[5] >> 11;
            ty = m_ty[5] & 3;
            chk("enabled", ep_enabled, en);
            chk("alloc", fifo_alloc_bytes, en ? m_ps[5] & 32'h7ff : 0);
            chk("buffers", ep_buffers, m_ty[5] >> 2 & 1 ? 2 : 1);
            chk("xfer_type", endpoint_transfer_type, ty);
            chk("packets", packets_per_uframe,
                hs && (ty == 1 || ty == 3) && nt != 3 ? nt : 0);
            chk("count_out", packet_byte_count, m_bc[5]);
        end
        // Null packet after DMA IN, suppressed or not.
        for (int s = 0; s < 2; s++)
        begin
            cfg(6, 512, 8 | s << 4 | 2);
            i_ep_engine_model.serve(6);
            repeat (4) @(posedge pclk);
            i_ep_engine_model.strobe(0);
            repeat (3) @(posedge pclk);
            chk("suppress", suppress_null_packet, s);
            chk("null_pend", send_null_packet, !s);
            i_ep_engine_model.strobe(1);
            repeat (2) @(posedge pclk);
            chk("null_done", send_null_packet, 0);
        end
        // Re-enabling resets the data toggle.
        tr_seen = 1'b0;
        cfg(6, 512, 2);
        cfg(6, 512, 10);
        repeat (2) @(posedge pclk);
        chk("toggle", {tr_seen, tr_ep}, 5'h16);
        // Received OUT length lands in the byte count.
        v = $random(seed) & 32'hffff;
        i_ep_engine_model.serve(7);
        i_ep_engine_model.rx(v);
        m_bc[7] = v;
        apb(1, 8'h1c, v);
        m_bc[6] = v;
        repeat (6) @(posedge pclk);
        chk_all();
        @(posedge pclk);
        usb_bus_reset <= 1'b1;
        @(posedge pclk);
        usb_bus_reset <= 1'b0;
        m_ps = '{default: 0};
        m_ty = '{default: 0};
        m_bc = '{default: 0};
        chk_all();
        give_verdict();
    end
endmodule : usb_endpoint_config_regs_test
